/* File: rtl/hmerr_duty_bins.sv */
// Purpose: Turn one measured throttle duty into CPU2 status event bits.
// Assumes: dutyValid pulses once per monitoring interval.
// Notes:   Duty is in 1/256 steps; 256 means the input was active throughout.
`timescale 1ns/1ps
module hmerr_duty_bins (
    // Measurement
    input  wire logic       dutyValid,
    input  wire logic [8:0] duty,
    input  wire logic [7:0] dutyLimit,
    // Events
    output logic      [7:0] events
);
    // ----------------------------------------
    // Bin decode, exactly one bin per sample below full duty, none at full duty
    // ----------------------------------------
    always_comb begin
        events = 8'h00;
        if (dutyValid) begin
            events[hmerr_pkg::BIT_ANY] = (duty != 9'h000);              // [R1]
            if (duty < hmerr_pkg::DUTY_12P5) begin
                events[1] = 1'b1;                                        // [R2]
            end else if (duty < hmerr_pkg::DUTY_25) begin
                events[2] = 1'b1;                                        // [R2]
            end else if (duty < hmerr_pkg::DUTY_50) begin
                events[3] = 1'b1;                                        // [R2]
            end else if (duty < hmerr_pkg::DUTY_75) begin
                events[4] = 1'b1;                                        // [R2]
            end else if (duty < hmerr_pkg::DUTY_FULL) begin
                events[5] = 1'b1;                                        // [R2]
            end
            events[hmerr_pkg::BIT_FULL] = (duty >= hmerr_pkg::DUTY_FULL); // [R3]
            events[hmerr_pkg::BIT_OVER] = (duty > {1'b0, dutyLimit});    // [R4]
        end
    end
endmodule

/* File: rtl/hmerr_pkg.sv */
// Purpose: Shared constants for the monitor error and temperature register slice.
// Assumes: Byte-wide register port driven by the serial host front end.
// Notes:   Offsets are the register addresses as seen by the host.
//
// What this block does
// [R1] Any nonzero throttle duty seen on the CPU2 throttle input sets status bit 0.
// [R2] Each measured duty below full sets exactly one bin bit among bits 1 to 5 by its range; full duty sets none.
// [R3] A throttle input active for the whole interval sets status bit 6.
// [R4] A duty above the programmed limit sets status bit 7.
// [R5] Only the over-limit bit feeds the host error flag.
// [R6] The throttle status register sits at 4Dh, is write-one-to-clear and resets to zero.
// [R7] A general pin driven low sets its low flag at 4Eh unless its mask bit is set.
// [R8] A fan tach count above its limit sets its fault bit at 4Fh; bits 7:4 read zero.
// [R9] Unfiltered zone 1 and 2 temperatures at 50h, 51h, 06h, 07h update by hardware.
// [R10] Temperatures at 52h and 53h take host writes or follow analog channels 11 and 15.
// [R11] Zone 1 and 2 temperature registers read 80h while their diode is faulty.
// [R12] Smoothed temperatures sit at 54h, 55h, 08h, 09h, read only, reset to zero.
// [R13] The smoothed values follow the spike smoothing control settings.
// [R14] Status bits stay set until the host writes a one to them.
// [R15] A set in the same cycle as a clear leaves the bit set.
package hmerr_pkg;
    localparam logic [7:0] ADDR_Z1B_RAW    = 8'h06;
    localparam logic [7:0] ADDR_Z2B_RAW    = 8'h07;
    localparam logic [7:0] ADDR_Z1B_SMOOTH = 8'h08;
    localparam logic [7:0] ADDR_Z2B_SMOOTH = 8'h09;
    localparam logic [7:0] ADDR_CPU2_THR   = 8'h4D;
    localparam logic [7:0] ADDR_GPIN_LOW   = 8'h4E;
    localparam logic [7:0] ADDR_FAN_FAULT  = 8'h4F;
    localparam logic [7:0] ADDR_Z1A_RAW    = 8'h50;
    localparam logic [7:0] ADDR_Z2A_RAW    = 8'h51;
    localparam logic [7:0] ADDR_INT_ZONE   = 8'h52;
    localparam logic [7:0] ADDR_EXT_ZONE   = 8'h53;
    localparam logic [7:0] ADDR_Z1A_SMOOTH = 8'h54;
    localparam logic [7:0] ADDR_Z2A_SMOOTH = 8'h55;
    localparam logic [7:0] RESET_VALUE     = 8'h00;
    localparam logic [7:0] DIODE_FAULT_VAL = 8'h80;
    localparam logic [7:0] FAN_FIELD_MASK  = 8'h0F;
    // Duty scale: 256 counts make a full interval
    localparam logic [8:0] DUTY_12P5       = 9'h020;
    localparam logic [8:0] DUTY_25         = 9'h040;
    localparam logic [8:0] DUTY_50         = 9'h080;
    localparam logic [8:0] DUTY_75         = 9'h0C0;
    localparam logic [8:0] DUTY_FULL       = 9'h100;
    localparam int         BIT_ANY         = 0;
    localparam int         BIT_FULL        = 6;
    localparam int         BIT_OVER        = 7;
endpackage

/* File: rtl/hmerr_regs.sv */
// Purpose: Error status and temperature value registers of the monitor.
// Assumes: Host port is a byte address with one-cycle read and write strobes.
// Notes:   Read data is registered; it appears the cycle after the read strobe.
`timescale 1ns/1ps
module hmerr_regs #(
    parameter int NUM_FANS = 4,
    parameter int TACH_W   = 16
) (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst_b,
    // Host register port
    input  wire logic [7:0]                 regAddr,
    input  wire logic                       regWrite,
    input  wire logic                       regRead,
    input  wire logic [7:0]                 regWdata,
    output logic      [7:0]                 regRdata,
    // Throttle measurement
    input  wire logic                       dutyValid,
    input  wire logic [8:0]                 duty,
    input  wire logic [7:0]                 dutyLimit,
    // General pins and mask
    input  wire logic [7:0]                 general_pin,
    input  wire logic [7:0]                 gpinMask,
    // Fan tachometers
    input  wire logic [NUM_FANS*TACH_W-1:0] tachCount,
    input  wire logic [NUM_FANS*TACH_W-1:0] tachLimit,
    // Temperature measurements
    input  wire logic                       tempValid,
    input  wire logic [7:0]                 z1aTemp,
    input  wire logic [7:0]                 z2aTemp,
    input  wire logic [7:0]                 z1bTemp,
    input  wire logic [7:0]                 z2bTemp,
    input  wire logic [3:0]                 diodeFault,
    input  wire logic                       smoothValid,
    input  wire logic [7:0]                 z1aSmooth,
    input  wire logic [7:0]                 z2aSmooth,
    input  wire logic [7:0]                 z1bSmooth,
    input  wire logic [7:0]                 z2bSmooth,
    // Analog channel source for internal and external zones
    input  wire logic                       zonesFromAnalog,
    input  wire logic                       analogValid,
    input  wire logic [7:0]                 analog_channel_eleven,
    input  wire logic [7:0]                 analog_channel_fifteen,
    // Host error flag
    output logic                            cpu2_over_limit_flag
);
    // ----------------------------------------
    // Status register state
    // ----------------------------------------
    logic [7:0]          thrEvents;
    logic [7:0]          thrFlags;
    logic [7:0]          gpinFlags;
    logic [NUM_FANS-1:0] fanFlags;
    logic [NUM_FANS-1:0] fanEvents;
    logic [7:0]          gpinEvents;
    logic [7:0]          thrClear;
    logic [7:0]          gpinClear;
    logic [NUM_FANS-1:0] fanClear;
    logic [7:0]          z1aRaw_r;
    logic [7:0]          z2aRaw_r;
    logic [7:0]          z1bRaw_r;
    logic [7:0]          z2bRaw_r;
    logic [7:0]          z1aSm_r;
    logic [7:0]          z2aSm_r;
    logic [7:0]          z1bSm_r;
    logic [7:0]          z2bSm_r;
    logic [7:0]          intZone_r;
    logic [7:0]          extZone_r;
    logic [7:0]          rdata_nxt;
    logic [7:0]          fanByte;

    // Throttle duty classification
    hmerr_duty_bins uBins (
        .dutyValid (dutyValid),
        .duty      (duty),
        .dutyLimit (dutyLimit),
        .events    (thrEvents)
    );

    // ----------------------------------------
    // Write-one-to-clear decode
    // ----------------------------------------
    assign thrClear  = (regWrite && regAddr == hmerr_pkg::ADDR_CPU2_THR)
                       ? regWdata : 8'h00;                          // [R6]
    assign gpinClear = (regWrite && regAddr == hmerr_pkg::ADDR_GPIN_LOW) ? regWdata : 8'h00;
    assign fanClear  = (regWrite && regAddr == hmerr_pkg::ADDR_FAN_FAULT)
                       ? regWdata[NUM_FANS-1:0] : '0;

    // Low pin sets its flag unless masked
    assign gpinEvents = ~general_pin & ~gpinMask;                   // [R7]

    // Tach count above limit, one comparator per fan
    for (genvar f = 0; f < NUM_FANS; f++) begin : gFan
        assign fanEvents[f] = tachCount[f*TACH_W +: TACH_W]
                              > tachLimit[f*TACH_W +: TACH_W];      // [R8]
    end

    // Sticky banks
    hmerr_sticky #(.WIDTH(8)) uThr (
        .clock     (clock),
        .rst_b     (rst_b),
        .setBits   (thrEvents),
        .clearBits (thrClear),
        .flags     (thrFlags)
    );
    hmerr_sticky #(.WIDTH(8)) uGpin (
        .clock     (clock),
        .rst_b     (rst_b),
        .setBits   (gpinEvents),
        .clearBits (gpinClear),
        .flags     (gpinFlags)
    );
    hmerr_sticky #(.WIDTH(NUM_FANS)) uFan (
        .clock     (clock),
        .rst_b     (rst_b),
        .setBits   (fanEvents),
        .clearBits (fanClear),
        .flags     (fanFlags)
    );

    // ----------------------------------------
    // Host error flag
    // ----------------------------------------
    // Bins and the full-duty bit are informational only
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cpu2_over_limit_flag <= 1'b0;
        end else begin
            cpu2_over_limit_flag <= thrFlags[hmerr_pkg::BIT_OVER]; // [R5]
        end
    end

    // ----------------------------------------
    // Unfiltered zone temperatures
    // ----------------------------------------
    // A faulty diode forces the fault code instead of a stale reading
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            z1aRaw_r <= hmerr_pkg::RESET_VALUE;
            z2aRaw_r <= hmerr_pkg::RESET_VALUE;
            z1bRaw_r <= hmerr_pkg::RESET_VALUE;
            z2bRaw_r <= hmerr_pkg::RESET_VALUE;
        end else if (tempValid) begin
            z1aRaw_r <= diodeFault[0] ? hmerr_pkg::DIODE_FAULT_VAL : z1aTemp; // [R9] [R11]
            z2aRaw_r <= diodeFault[1] ? hmerr_pkg::DIODE_FAULT_VAL : z2aTemp; // [R9] [R11]
            z1bRaw_r <= diodeFault[2] ? hmerr_pkg::DIODE_FAULT_VAL : z1bTemp; // [R9] [R11]
            z2bRaw_r <= diodeFault[3] ? hmerr_pkg::DIODE_FAULT_VAL : z2bTemp; // [R9] [R11]
        end
    end

    // ----------------------------------------
    // Smoothed zone temperatures
    // ----------------------------------------
    // Filter shaped by the smoothing control lives upstream; values land here
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            z1aSm_r <= hmerr_pkg::RESET_VALUE;
            z2aSm_r <= hmerr_pkg::RESET_VALUE;
            z1bSm_r <= hmerr_pkg::RESET_VALUE;
            z2bSm_r <= hmerr_pkg::RESET_VALUE;
        end else if (smoothValid) begin
            z1aSm_r <= diodeFault[0] ? hmerr_pkg::DIODE_FAULT_VAL : z1aSmooth; // [R12] [R13] [R11]
            z2aSm_r <= diodeFault[1] ? hmerr_pkg::DIODE_FAULT_VAL : z2aSmooth; // [R12] [R13] [R11]
            z1bSm_r <= diodeFault[2] ? hmerr_pkg::DIODE_FAULT_VAL : z1bSmooth; // [R12] [R13] [R11]
            z2bSm_r <= diodeFault[3] ? hmerr_pkg::DIODE_FAULT_VAL : z2bSmooth; // [R12] [R13] [R11]
        end
    end

    // ----------------------------------------
    // Internal and external zones
    // ----------------------------------------
    // Analog source, when selected, overrides host writes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            intZone_r <= hmerr_pkg::RESET_VALUE;
            extZone_r <= hmerr_pkg::RESET_VALUE;
        end else if (zonesFromAnalog) begin
            if (analogValid) begin
                intZone_r <= analog_channel_eleven;    // [R10]
                extZone_r <= analog_channel_fifteen;   // [R10]
            end
        end else if (regWrite) begin
            if (regAddr == hmerr_pkg::ADDR_INT_ZONE) begin
                intZone_r <= regWdata;                 // [R10]
            end
            if (regAddr == hmerr_pkg::ADDR_EXT_ZONE) begin
                extZone_r <= regWdata;                 // [R10]
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Reserved fan bits 7:4 read zero
    always_comb begin
        fanByte = 8'h00;
        fanByte[NUM_FANS-1:0] = fanFlags;
        fanByte = fanByte & hmerr_pkg::FAN_FIELD_MASK;   // [R8]
    end

    // Unmapped addresses read zero
    always_comb begin
        case (regAddr)
            hmerr_pkg::ADDR_Z1B_RAW:    rdata_nxt = z1bRaw_r;
            hmerr_pkg::ADDR_Z2B_RAW:    rdata_nxt = z2bRaw_r;
            hmerr_pkg::ADDR_Z1B_SMOOTH: rdata_nxt = z1bSm_r;
            hmerr_pkg::ADDR_Z2B_SMOOTH: rdata_nxt = z2bSm_r;
            hmerr_pkg::ADDR_CPU2_THR:   rdata_nxt = thrFlags;
            hmerr_pkg::ADDR_GPIN_LOW:   rdata_nxt = gpinFlags;
            hmerr_pkg::ADDR_FAN_FAULT:  rdata_nxt = fanByte;
            hmerr_pkg::ADDR_Z1A_RAW:    rdata_nxt = z1aRaw_r;
            hmerr_pkg::ADDR_Z2A_RAW:    rdata_nxt = z2aRaw_r;
            hmerr_pkg::ADDR_INT_ZONE:   rdata_nxt = intZone_r;
            hmerr_pkg::ADDR_EXT_ZONE:   rdata_nxt = extZone_r;
            hmerr_pkg::ADDR_Z1A_SMOOTH: rdata_nxt = z1aSm_r;
            hmerr_pkg::ADDR_Z2A_SMOOTH: rdata_nxt = z2aSm_r;
            default:                    rdata_nxt = 8'h00;
        endcase
    end

    // Read data holds until the next read
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= rdata_nxt;
        end
    end
endmodule

/* File: rtl/hmerr_sticky.sv */
// Purpose: Bank of sticky write-one-to-clear status bits.
// Assumes: Set and clear are one-cycle qualified strobes.
// Notes:   Set beats clear so no event is dropped.
`timescale 1ns/1ps
module hmerr_sticky #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Events and host clear
    input  wire logic [WIDTH-1:0] setBits,
    input  wire logic [WIDTH-1:0] clearBits,
    // State
    output logic      [WIDTH-1:0] flags
);
    // ----------------------------------------
    // Per-bit sticky flags
    // ----------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : gBit
        // Set wins over a clear in the same cycle
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
                flags[i] <= 1'b0;
            end else if (setBits[i]) begin
                flags[i] <= 1'b1;                        // [R15]
            end else if (clearBits[i]) begin
                flags[i] <= 1'b0;                        // [R14]
            end
        end
    end
endmodule

/* File: verif/hmerr_host.sv */
// Purpose: Host model that reads and clears registers over the byte port.
// Assumes: One-cycle strobes; read data is taken one cycle after the strobe.
// Notes:   Released address and data are inverted so stale values never pass.
`timescale 1ns/1ps
module hmerr_host (
    // Clock
    input  wire logic       clock,
    // Register port
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regWdata,
    input  wire logic [7:0] regRdata
);
    // Idle port at time zero
    initial begin
        regAddr  = 8'h00;
        regWrite = 1'b0;
        regRead  = 1'b0;
        regWdata = 8'h00;
    end
    // Write strobe for one edge; a one clears on status registers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        regAddr  <= ~a;
        regWdata <= ~d;
    endtask
    // Read strobe; data is taken at the edge after the strobe is sampled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(posedge clock);
        d = regRdata;
    endtask
endmodule

/* File: verif/hmerr_regs_chk.sv */
// Purpose: Port-level assertions for the error and temperature register slice.
// Assumes: Read data lands one cycle after the strobe; flag trails bit 7 by one cycle.
// Notes:   Watches design ports only; bound to every instance of the register block.
`timescale 1ns/1ps
module hmerr_regs_chk (
    // Clock, reset and host port
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic [7:0] regAddr,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    // Events and flag
    input wire logic       dutyValid,
    input wire logic [8:0] duty,
    input wire logic [7:0] dutyLimit,
    input wire logic [7:0] general_pin,
    input wire logic [7:0] gpinMask,
    input wire logic       cpu2_over_limit_flag
);
    logic       over;
    logic       clr;
    logic [7:0] pinEvt;
    // Decoded causes; pinEvt mirrors the unmasked low pins
    assign over   = dutyValid && (duty > {1'b0, dutyLimit});
    assign clr    = regWrite && regAddr == hmerr_pkg::ADDR_CPU2_THR && regWdata[7];
    assign pinEvt = ~general_pin & ~gpinMask;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    AST_OVER_SETS_FLAG:
        assert property (over |-> ##2 cpu2_over_limit_flag) else $error("flag missed over");
    AST_FLAG_CAUSE:
        assert property ($rose(cpu2_over_limit_flag) |-> $past(over, 2))
        else $error("flag rose without over-limit duty");
    AST_FLAG_STICKY:
        assert property (cpu2_over_limit_flag && !$past(clr) |=> cpu2_over_limit_flag)
        else $error("flag dropped without clear");
    AST_CLEAR_DROPS:
        assert property (clr && !over |-> ##2 !cpu2_over_limit_flag) else $error("clear ignored");
    AST_SET_BEATS_CLEAR:
        assert property (clr && over |-> ##2 cpu2_over_limit_flag) else $error("set lost to clear");
    AST_FAN_RESERVED:
        assert property (regRead && regAddr == hmerr_pkg::ADDR_FAN_FAULT |=> regRdata[7:4] == 4'h0)
        else $error("fan reserved bits nonzero");
    AST_RESET_CLEAN:
        assert property ($rose(rst_b) |-> regRdata == 8'h00 && !cpu2_over_limit_flag)
        else $error("outputs not clear after reset");
    AST_GPIN_SETS:
        assert property (regRead && regAddr == hmerr_pkg::ADDR_GPIN_LOW && $past(rst_b)
                         |=> (regRdata & $past(pinEvt, 2)) == $past(pinEvt, 2))
        else $error("low pin flag missing");
    // Main scenarios reached
    COV_SET_AND_CLEAR: cover property (clr && over);
    COV_FAN_READ:      cover property (regRead && regAddr == hmerr_pkg::ADDR_FAN_FAULT);
    COV_FLAG_FALL:     cover property ($fell(cpu2_over_limit_flag));
endmodule
bind hmerr_regs hmerr_regs_chk i_chk (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .dutyValid(dutyValid), .duty(duty), .dutyLimit(dutyLimit), .general_pin(general_pin),
    .gpinMask(gpinMask), .cpu2_over_limit_flag(cpu2_over_limit_flag));

/* File: verif/test_monitor_error_and_temp_regs.sv */
// Purpose: Self-checking bench for the error and temperature register slice.
// Assumes: Seeded random stimulus with corner duties, pins, counts and temperatures.
// Notes:   Expected values come from bench functions, never from design outputs.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_monitor_error_and_temp_regs;
    localparam logic [7:0] ALL [14] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h4D, 8'h4E, 8'h4F,
        8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h30};
    localparam logic [7:0] RAW [4] = '{8'h50, 8'h51, 8'h06, 8'h07};
    localparam logic [7:0] SMO [4] = '{8'h54, 8'h55, 8'h08, 8'h09};
    localparam logic [8:0] CORN [12] = '{9'h000, 9'h001, 9'h01F, 9'h020, 9'h03F, 9'h040,
        9'h07F, 9'h080, 9'h0BF, 9'h0C0, 9'h0FF, 9'h100};
    logic clock = 1'b0, rst_b = 1'b0, regWrite, regRead, dutyValid, tempValid, smoothValid;
    logic zonesFromAnalog, analogValid, flag;
    logic [7:0] regAddr, regWdata, regRdata, dutyLimit, general_pin, gpinMask, an11, an15;
    logic [7:0] got, acc, ex, l, tIn [4], sIn [4];
    logic [8:0] duty, d;
    logic [3:0] diodeFault;
    logic [63:0] tachCount, tachLimit;
    int error_cnt = 0, n_tests = 0, seed = 32247, cyc = 0, i, f, r;
    // Clock of 25 ns period
    always #12.5 clock = ~clock;
    hmerr_host i_host (.clock(clock), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata));
    hmerr_regs #(.NUM_FANS(4), .TACH_W(16)) i_dut (.clock(clock), .rst_b(rst_b),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regRdata(regRdata), .dutyValid(dutyValid), .duty(duty), .dutyLimit(dutyLimit),
        .general_pin(general_pin), .gpinMask(gpinMask), .tachCount(tachCount),
        .tachLimit(tachLimit), .tempValid(tempValid), .z1aTemp(tIn[0]), .z2aTemp(tIn[1]),
        .z1bTemp(tIn[2]), .z2bTemp(tIn[3]), .diodeFault(diodeFault),
        .smoothValid(smoothValid), .z1aSmooth(sIn[0]), .z2aSmooth(sIn[1]),
        .z1bSmooth(sIn[2]), .z2bSmooth(sIn[3]), .zonesFromAnalog(zonesFromAnalog),
        .analogValid(analogValid), .analog_channel_eleven(an11),
        .analog_channel_fifteen(an15), .cpu2_over_limit_flag(flag));
    // Status pattern of one duty sample: bins are exclusive, full duty has no bin
    function automatic logic [7:0] expDuty(input logic [8:0] v, input logic [7:0] lim);
        expDuty = {v > {1'b0, lim}, v == 9'h100, v >= 9'h0C0 && v < 9'h100,
            v >= 9'h080 && v < 9'h0C0, v >= 9'h040 && v < 9'h080,
            v >= 9'h020 && v < 9'h040, v < 9'h020, v != 9'h000};
    endfunction
    task automatic chkRd(input logic [7:0] a, input logic [7:0] e, input string nm);
        i_host.rd(a, got);
        `CHK(nm, e, got)
    endtask
    task automatic pulseDuty(input logic [8:0] v, input logic [7:0] lim);
        @(posedge clock);
        dutyValid <= 1'b1;
        duty      <= v;
        dutyLimit <= lim;
        @(posedge clock);
        dutyValid <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        {dutyValid, tempValid, smoothValid, zonesFromAnalog, analogValid} = 5'h00;
        {duty, dutyLimit, gpinMask, an11, an15, diodeFault} = '0;
        general_pin = 8'hFF;
        {tachCount, tachLimit} = '0;
        tIn = '{4{8'h00}};
        sIn = '{4{8'h00}};
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        for (i = 0; i < 14; i++) chkRd(ALL[i], 8'h00, "reset value");
        $display("reset values done");
        // Duty corners then random duties; status accumulates until cleared
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            d = (i < 12) ? CORN[i] : 9'((r & 32'h7FFF_FFFF) % 257);
            l = i[0] ? d[7:0] : r[15:8];
            if (i % 5 == 0) begin
                i_host.wr(hmerr_pkg::ADDR_CPU2_THR, 8'hFF);
                acc = 8'h00;
            end
            pulseDuty(d, l);
            acc |= expDuty(d, l);
            chkRd(hmerr_pkg::ADDR_CPU2_THR, acc, "throttle status");
            `CHK("over flag", acc[7], flag)
        end
        // Clear and full-duty event on the same edge
        i_host.wr(hmerr_pkg::ADDR_CPU2_THR, 8'hFF);
        fork
            i_host.wr(hmerr_pkg::ADDR_CPU2_THR, 8'hFF);
            pulseDuty(9'h100, 8'h00);
        join
        chkRd(hmerr_pkg::ADDR_CPU2_THR, 8'hC1, "set beats clear");
        i_host.wr(hmerr_pkg::ADDR_CPU2_THR, 8'hFF);
        chkRd(hmerr_pkg::ADDR_CPU2_THR, 8'h00, "throttle cleared");
        $display("throttle tests done");
        // Low pins, masked and unmasked
        for (i = 0; i < 8; i++) begin
            @(posedge clock);
            general_pin <= (i == 0) ? 8'h00 : 8'($random(seed));
            gpinMask    <= (i == 0) ? 8'hFF : 8'($random(seed));
            @(posedge clock);
            ex = ~general_pin & ~gpinMask;
            @(posedge clock);
            general_pin <= 8'hFF;
            chkRd(hmerr_pkg::ADDR_GPIN_LOW, ex, "pin flags");
            i_host.wr(hmerr_pkg::ADDR_GPIN_LOW, 8'hFF);
            chkRd(hmerr_pkg::ADDR_GPIN_LOW, 8'h00, "pin cleared");
        end
        // Fan counts against limits, one fan exactly at its limit
        for (i = 0; i < 8; i++) begin
            @(posedge clock);
            for (f = 0; f < 4; f++) begin
                r = $random(seed);
                tachLimit[f*16+:16] <= r[15:0];
                tachCount[f*16+:16] <= (f == i % 4) ? r[15:0] : r[31:16];
            end
            @(posedge clock);
            ex = 8'h00;
            for (f = 0; f < 4; f++) ex[f] = tachCount[f*16+:16] > tachLimit[f*16+:16];
            @(posedge clock);
            tachCount <= '0;
            chkRd(hmerr_pkg::ADDR_FAN_FAULT, ex, "fan flags");
            i_host.wr(hmerr_pkg::ADDR_FAN_FAULT, 8'hFF);
            chkRd(hmerr_pkg::ADDR_FAN_FAULT, 8'h00, "fan cleared");
        end
        $display("pin and fan tests done");
        // Raw and smoothed temperatures with diode faults; host writes to raw registers ignored
        for (i = 0; i < 4; i++) begin
            @(posedge clock);
            for (f = 0; f < 4; f++) tIn[f] <= 8'($random(seed));
            for (f = 0; f < 4; f++) sIn[f] <= 8'($random(seed));
            diodeFault <= 4'($random(seed));
            {tempValid, smoothValid} <= 2'h3;
            @(posedge clock);
            {tempValid, smoothValid} <= 2'h0;
            i_host.wr(RAW[i], 8'h5A);
            for (f = 0; f < 4; f++) begin
                chkRd(RAW[f], diodeFault[f] ? 8'h80 : tIn[f], "raw temp");
                chkRd(SMO[f], diodeFault[f] ? 8'h80 : sIn[f], "smooth temp");
            end
        end
        // Both zones by host write, then both zones from analog channels
        i_host.wr(hmerr_pkg::ADDR_INT_ZONE, 8'h96);
        chkRd(hmerr_pkg::ADDR_INT_ZONE, 8'h96, "host zone");
        i_host.wr(hmerr_pkg::ADDR_EXT_ZONE, 8'hA5);
        chkRd(hmerr_pkg::ADDR_EXT_ZONE, 8'hA5, "host zone");
        @(posedge clock);
        {an11, an15} <= 16'($random(seed));
        {zonesFromAnalog, analogValid} <= 2'h3;
        @(posedge clock);
        analogValid <= 1'b0;
        i_host.wr(hmerr_pkg::ADDR_EXT_ZONE, 8'h3C);
        chkRd(hmerr_pkg::ADDR_INT_ZONE, an11, "analog zone");
        chkRd(hmerr_pkg::ADDR_EXT_ZONE, an15, "analog zone");
        $display("temperature tests done");
        wrap_up();
    end
endmodule
